// >>> epwm_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "epwm_defines.svh"

module epwm_core
    import epwm_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             bridge_output_a_o,
    output logic             bridge_output_b_o,
    output logic             bridge_output_c_o,
    output logic             bridge_output_d_o
);

    // ==================================================
    // software registers
    logic [7:0]  duty_high_byte_r;
    logic [7:0]  pwm_control_reg_r;
    logic [7:0]  period_register_r;
    logic [7:0]  timer_ctl_r;
    logic [7:0]  duty_shadow_reg_r;
    logic [1:0]  duty_latch_r;
    logic        mod_r;
    logic        ack_r;
    logic [31:0] rdata_r;

    // ==================================================
    // decode
    logic        wb_req;
    logic        wb_wr;
    logic        lane0;
    logic        pwm_mode;
    logic        timer_run;
    logic [1:0]  ps_sel;
    logic [1:0]  out_cfg;
    logic [9:0]  duty_buf;
    logic [9:0]  duty_active;
    logic [9:0]  ext_count;
    logic [7:0]  period_timer;
    logic [1:0]  low_bits;
    logic        period_end;
    logic [3:0]  pins;
    logic        mod_nxt;
    logic        duty_match;
    logic        mod_out;
    logic [31:0] rdata_nxt;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction

    assign wb_req    = wb_cyc_i && wb_stb_i && !ack_r;
    assign wb_wr     = wb_req && wb_we_i;
    assign lane0     = wb_sel_i[0];
    assign pwm_mode  = pwm_control_reg_r[`EPWM_CTL_MODE_BIT];
    assign timer_run = timer_ctl_r[`EPWM_TCTL_ON_BIT];
    assign ps_sel    = timer_ctl_r[`EPWM_TCTL_PS_HI:`EPWM_TCTL_PS_LO];
    assign out_cfg   = pwm_control_reg_r[`EPWM_CTL_CFG_HI:`EPWM_CTL_CFG_LO];

    // upper eight from the high-byte register, lower two from control
    assign duty_buf    = {duty_high_byte_r,
                          pwm_control_reg_r[`EPWM_CTL_LSB_HI:`EPWM_CTL_LSB_LO]};
    assign duty_active = {duty_shadow_reg_r, duty_latch_r};
    assign ext_count   = {period_timer, low_bits};

    // ==================================================
    // period timer with prescaler
    epwm_timebase u_timebase (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .run_i        (timer_run),
        .ps_sel_i     (ps_sel),
        .period_i     (period_register_r),
        .timer_o      (period_timer),
        .low_o        (low_bits),
        .period_end_o (period_end)
    );

    // ==================================================
    // bus slave: one wait state, ack for one cycle
    // the ack flop masks the request, so a master still holding its strobe
    // on the ack edge is never taken twice
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wb_req;
        end
    end

    assign wb_ack_o = ack_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            duty_high_byte_r  <= `EPWM_RST_BYTE;
            pwm_control_reg_r <= `EPWM_RST_BYTE;
            period_register_r <= `EPWM_RST_PERIOD;
            timer_ctl_r       <= `EPWM_RST_BYTE;
        end else if (wb_wr && lane0) begin
            // duty fields take writes at any moment; they reach the
            // waveform only through the shadow at a period end
            if (hit(wb_adr_i, `EPWM_OFS_DUTY_HIGH)) begin
                duty_high_byte_r <= wb_dat_i[7:0];
            end
            if (hit(wb_adr_i, `EPWM_OFS_CONTROL)) begin
                pwm_control_reg_r <= wb_dat_i[7:0];
            end
            if (hit(wb_adr_i, `EPWM_OFS_PERIOD)) begin
                period_register_r <= wb_dat_i[7:0];
            end
            if (hit(wb_adr_i, `EPWM_OFS_TIMER_CTL)) begin
                timer_ctl_r <= {5'h00, wb_dat_i[2:0]};
            end
        end
    end

    // ==================================================
    // duty double buffer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            duty_shadow_reg_r <= `EPWM_RST_BYTE;
            duty_latch_r      <= 2'h0;
        end else if (period_end) begin
            duty_shadow_reg_r <= duty_buf[9:2];
            duty_latch_r      <= duty_buf[1:0];
        end else if (wb_wr && lane0 && !pwm_mode && hit(wb_adr_i, `EPWM_OFS_SHADOW)) begin
            // writable only outside PWM mode; ignored otherwise
            duty_shadow_reg_r <= wb_dat_i[7:0];
        end
    end

    // ==================================================
    // read mux, unmapped offsets read as zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (hit(wb_adr_i, `EPWM_OFS_DUTY_HIGH)) begin
            rdata_nxt[7:0] = duty_high_byte_r;
        end else if (hit(wb_adr_i, `EPWM_OFS_CONTROL)) begin
            rdata_nxt[7:0] = pwm_control_reg_r;
        end else if (hit(wb_adr_i, `EPWM_OFS_PERIOD)) begin
            rdata_nxt[7:0] = period_register_r;
        end else if (hit(wb_adr_i, `EPWM_OFS_TIMER_CTL)) begin
            rdata_nxt[7:0] = timer_ctl_r;
        end else if (hit(wb_adr_i, `EPWM_OFS_SHADOW)) begin
            rdata_nxt[7:0] = duty_shadow_reg_r;
        end else if (hit(wb_adr_i, `EPWM_OFS_STATUS)) begin
            rdata_nxt[7:0] = period_timer;
            rdata_nxt[`EPWM_STAT_OUT_BIT] = mod_out;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_r <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign wb_dat_o = rdata_r;

    // ==================================================
    // modulated waveform
    // the compare uses the buffered value, so a duty write mid-period
    // cannot cut the running pulse short; a duty past the period never
    // matches and the output simply stays active
    // the match gates the output in its own cycle; leaving it to the flop
    // alone would stretch every pulse by one clock
    assign duty_match = (ext_count == duty_active);
    assign mod_out    = mod_r && !duty_match;

    always_comb begin
        mod_nxt = mod_r;
        if (!pwm_mode || !timer_run) begin
            mod_nxt = 1'b0;
        end else if (period_end) begin
            mod_nxt = (duty_buf != `EPWM_RST_DUTY);
        end else if (duty_match) begin
            mod_nxt = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mod_r <= 1'b0;
        end else begin
            mod_r <= mod_nxt;
        end
    end

    // ==================================================
    // output steering
    epwm_steer u_steer (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .en_i  (pwm_mode),
        .cfg_i (out_cfg),
        .mod_i (mod_out),
        .out_o (pins)
    );

    assign bridge_output_a_o = pins[0];
    assign bridge_output_b_o = pins[1];
    assign bridge_output_c_o = pins[2];
    assign bridge_output_d_o = pins[3];

    // ==================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    shadow_load_a: assert property (
        period_end |=> duty_active == $past(duty_buf))
        else $error("shadow not loaded at period end");

    shadow_hold_a: assert property (
        !period_end && pwm_mode |=> $stable(duty_active))
        else $error("active duty changed inside a period");

    shadow_ro_a: assert property (
        wb_wr && pwm_mode && hit(wb_adr_i, `EPWM_OFS_SHADOW) && !period_end
        |=> duty_shadow_reg_r == $past(duty_shadow_reg_r))
        else $error("shadow written in PWM mode");

    duty_lsb_a: assert property (
        period_end |=> duty_latch_r == $past(pwm_control_reg_r[5:4]))
        else $error("duty low bits not from control bits");

    clear_match_a: assert property (
        pwm_mode && timer_run && !period_end && ext_count == duty_active |=> !mod_r)
        else $error("output not cleared on duty match");

    period_start_a: assert property (
        pwm_mode && timer_run && period_end && duty_buf != 10'h000
        |=> mod_r ##1 (bridge_output_a_o || out_cfg != 2'h0))
        else $error("output not set at period start");

    never_clear_a: assert property (
        pwm_mode && timer_run && mod_r && !period_end && duty_active > {period_register_r, 2'h3} |=> mod_r)
        else $error("output cleared with duty beyond period");

    single_out_a: assert property (
        pwm_mode && out_cfg == 2'h0 |=> bridge_output_a_o == $past(mod_out) && !bridge_output_b_o
                                        && !bridge_output_c_o && !bridge_output_d_o)
        else $error("single output pattern wrong");

    forward_out_a: assert property (
        pwm_mode && out_cfg == 2'h1 |=> bridge_output_a_o && !bridge_output_b_o && !bridge_output_c_o
                                        && bridge_output_d_o == $past(mod_out))
        else $error("forward bridge pattern wrong");

    reverse_out_a: assert property (
        pwm_mode && out_cfg == 2'h3 |=> !bridge_output_a_o && bridge_output_b_o == $past(mod_out)
                                        && bridge_output_c_o && !bridge_output_d_o)
        else $error("reverse bridge pattern wrong");

    bus_ack_a: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held for more than one cycle");

    ack_resp_a: assert property (
        wb_req |=> wb_ack_o)
        else $error("ack missing one cycle after request");

    rdata_hold_a: assert property (
        !(wb_req && !wb_we_i) |=> $stable(wb_dat_o))
        else $error("read data changed without a read");

    read_period_a: assert property (
        wb_req && !wb_we_i && hit(wb_adr_i, `EPWM_OFS_PERIOD)
        |=> wb_dat_o == {24'h00_0000, $past(period_register_r)})
        else $error("period register read back wrong");

    period_write_a: assert property (
        wb_wr && lane0 && hit(wb_adr_i, `EPWM_OFS_PERIOD)
        |=> period_register_r == $past(wb_dat_i[7:0]))
        else $error("period register write lost");

    // byte lane zero carries every register, so a write without it lands nowhere
    lane_gate_a: assert property (
        wb_wr && !lane0 |=> $stable(period_register_r) && $stable(duty_high_byte_r))
        else $error("write landed without its byte lane");

    wrap_zero_a: assert property (
        period_end |=> period_timer == 8'h00 && low_bits == 2'h0)
        else $error("extended count not restarted at period end");

    timer_step_a: assert property (
        timer_run && !period_end
        |=> period_timer == $past(period_timer) || period_timer == $past(period_timer) + 8'h01)
        else $error("period timer skipped a step");

    timer_off_a: assert property (
        !timer_run |=> !mod_r && period_timer == 8'h00)
        else $error("waveform or timer alive with timer off");

    duty_zero_a: assert property (
        period_end && duty_buf == `EPWM_RST_DUTY |=> !mod_r)
        else $error("zero duty set the output");

    mode_off_a: assert property (
        !pwm_mode |=> pins == 4'h0)
        else $error("pins driven with PWM mode off");

    half_out_a: assert property (
        pwm_mode && out_cfg == 2'h2 |=> bridge_output_a_o == $past(mod_out)
                                        && bridge_output_b_o == $past(mod_out)
                                        && !bridge_output_c_o && !bridge_output_d_o)
        else $error("half bridge pattern wrong");

endmodule

`default_nettype wire

// >>> epwm_defines.svh
`ifndef EPWM_DEFINES_SVH
`define EPWM_DEFINES_SVH

// ==================================================
// register byte offsets
`define EPWM_OFS_DUTY_HIGH   8'h00
`define EPWM_OFS_CONTROL     8'h04
`define EPWM_OFS_PERIOD      8'h08
`define EPWM_OFS_TIMER_CTL   8'h0C
`define EPWM_OFS_SHADOW      8'h10
`define EPWM_OFS_STATUS      8'h14

// ==================================================
// control register fields
`define EPWM_CTL_MODE_BIT    0
`define EPWM_CTL_LSB_HI      5
`define EPWM_CTL_LSB_LO      4
`define EPWM_CTL_CFG_HI      7
`define EPWM_CTL_CFG_LO      6

// ==================================================
// timer control fields
`define EPWM_TCTL_PS_HI      1
`define EPWM_TCTL_PS_LO      0
`define EPWM_TCTL_ON_BIT     2

// ==================================================
// status fields
`define EPWM_STAT_OUT_BIT    8

// ==================================================
// reset values
`define EPWM_RST_BYTE        8'h00
`define EPWM_RST_PERIOD      8'hFF
`define EPWM_RST_DUTY        10'h000

// ==================================================
// timing: one timer step spans four oscillator phases times the prescale factor
`define EPWM_PHASES          4

`endif

// >>> epwm_pkg.sv
package epwm_pkg;

    typedef enum logic [1:0] {
        EPWM_CFG_SINGLE  = 2'h0,
        EPWM_CFG_FWD     = 2'h1,
        EPWM_CFG_HALF    = 2'h2,
        EPWM_CFG_REV     = 2'h3
    } epwm_cfg_t;

    typedef enum logic [1:0] {
        EPWM_PS_1        = 2'h0,
        EPWM_PS_4        = 2'h1,
        EPWM_PS_16       = 2'h2,
        EPWM_PS_16B      = 2'h3
    } epwm_ps_t;

endpackage

// >>> epwm_timebase.sv
`timescale 1ns/1ps
`default_nettype none
`include "epwm_defines.svh"

module epwm_timebase
    import epwm_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       run_i,
    input  wire logic [1:0] ps_sel_i,
    input  wire logic [7:0] period_i,
    output logic      [7:0] timer_o,
    output logic      [1:0] low_o,
    output logic            period_end_o
);

    // ==================================================
    // prescaler: 4 phases times factor 1, 4 or 16
    logic [5:0] pre_r;
    logic [5:0] pre_top;
    logic       step;

    assign pre_top = (ps_sel_i == EPWM_PS_1) ? 6'h03 :
                     (ps_sel_i == EPWM_PS_4) ? 6'h0F : 6'h3F;
    assign step = run_i && (pre_r == pre_top);
    // low bits advance once per prescale clocks, extending the timer
    assign low_o = (ps_sel_i == EPWM_PS_1) ? pre_r[1:0] :
                   (ps_sel_i == EPWM_PS_4) ? pre_r[3:2] : pre_r[5:4];
    assign period_end_o = step && (timer_o == period_i);

    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            pre_r <= 6'h00;
        end else if (step) begin
            pre_r <= 6'h00;
        end else begin
            pre_r <= pre_r + 6'h01;
        end
    end

    // a stopped timer restarts from zero, so a new shorter period never waits out a wrap
    always_ff @(posedge clk_i) begin
        if (rst_i || !run_i) begin
            timer_o <= 8'h00;
        end else if (period_end_o) begin
            timer_o <= 8'h00;
        end else if (step) begin
            timer_o <= timer_o + 8'h01;
        end
    end

endmodule

`default_nettype wire

// >>> epwm_steer.sv
`timescale 1ns/1ps
`default_nettype none

module epwm_steer
    import epwm_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    input  wire logic       en_i,
    input  wire logic [1:0] cfg_i,
    input  wire logic       mod_i,
    output logic      [3:0] out_o
);

    // out_o bit order: {d, c, b, a}
    logic [3:0] out_nxt;

    assign out_nxt = !en_i                   ? 4'h0 :
                     (cfg_i == EPWM_CFG_SINGLE) ? {3'h0, mod_i} :
                     (cfg_i == EPWM_CFG_HALF)   ? {2'h0, mod_i, mod_i} :
                     (cfg_i == EPWM_CFG_FWD)    ? {mod_i, 2'h0, 1'b1} :
                                                  {1'b0, 1'b1, mod_i, 1'b0};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_o <= 4'h0;
        end else begin
            out_o <= out_nxt;
        end
    end

endmodule

`default_nettype wire

// >>> epwm_bridge_load.sv
`timescale 1ns/1ps
`default_nettype none

// ==========
// switch stage load: counts the cycles each gate input is driven high
module epwm_bridge_load (
    input  wire logic             clk_i,
    input  wire logic             clr_i,
    input  wire logic [3:0]       pin_i,
    output logic      [3:0][15:0] hi_o
);
    // a window as long as one period sees the same count at any phase
    always_ff @(posedge clk_i) begin
        for (int k = 0; k < 4; k++) begin
            hi_o[k] <= clr_i ? 16'h0 : hi_o[k] + {15'h0, pin_i[k]};
        end
    end
endmodule

`default_nettype wire

// >>> enhanced_pwm_duty_and_outputs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "epwm_defines.svh"

// ==========
// bench top
module enhanced_pwm_duty_and_outputs_tb_top;
    import epwm_pkg::*;

    logic             clk_i    = 1'b0;
    logic             rst_i    = 1'b1;
    logic             wb_cyc   = 1'b0;
    logic             wb_stb   = 1'b0;
    logic             wb_we    = 1'b0;
    logic [3:0]       wb_sel   = 4'hF;
    logic [7:0]       wb_adr   = 8'h00;
    logic [31:0]      wb_dat_w = 32'h0;
    logic [31:0]      wb_dat_r;
    logic             wb_ack;
    logic [3:0]       pins;
    logic             clr      = 1'b0;
    logic [3:0][15:0] hi;
    logic [7:0]       zofs [5] = '{8'h00, 8'h04, 8'h0C, 8'h10, 8'h18};
    int               err_total   = 0;
    int               comparisons = 0;
    int               cycles      = 0;
    int               seed        = 32'h7325;

    initial begin
        forever begin
            #25;
            clk_i = ~clk_i;
        end
    end

    epwm_core i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
        .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
        .bridge_output_a_o(pins[0]), .bridge_output_b_o(pins[1]),
        .bridge_output_c_o(pins[2]), .bridge_output_d_o(pins[3])
    );

    epwm_bridge_load i_load (.clk_i(clk_i), .clr_i(clr), .pin_i(pins), .hi_o(hi));

    task test_done();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // runaway guard, well above the longest sequence
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            test_done();
        end
    end

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // waits for ack as long as it takes; only the runaway guard ends a hang
    task wb(input logic we, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= a;
        wb_dat_w <= {24'h0, d};
        do begin
            @(posedge clk_i);
        end while (wb_ack !== 1'b1);
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task measure(input int len);
        @(posedge clk_i);
        clr <= 1'b1;
        @(posedge clk_i);
        clr <= 1'b0;
        repeat (len) @(posedge clk_i);
        #1;
    endtask

    function int exp_hi(input logic [1:0] cfg, input int k, input int m, input int len);
        case (cfg)
            EPWM_CFG_SINGLE: return (k == 0) ? m : 0;
            EPWM_CFG_HALF:   return (k < 2) ? m : 0;
            EPWM_CFG_FWD:    return (k == 0) ? len : (k == 3) ? m : 0;
            default:         return (k == 2) ? len : (k == 1) ? m : 0;
        endcase
    endfunction

    initial begin
        logic [31:0] q;
        logic [31:0] r;
        logic [1:0]  cfg;
        logic [1:0]  ps;
        int          f;
        int          per;
        int          len;
        int          duty;
        int          m;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, `EPWM_OFS_PERIOD, 8'h00, q);
        check("period reset", q, 32'hFF);
        for (int i = 0; i < 5; i++) begin
            wb(1'b0, zofs[i], 8'h00, q);
            check("zero after reset", q, 32'h0);
        end
        check("pins after reset", {28'h0, pins}, 32'h0);
        wb_sel <= 4'hE;
        wr(`EPWM_OFS_PERIOD, 8'h12);
        wb_sel <= 4'hF;
        wb(1'b0, `EPWM_OFS_PERIOD, 8'h00, q);
        check("lane off write", q, 32'hFF);
        $display("reset test done");
        // every output code at every prescale, corners first
        for (int i = 0; i < 16; i++) begin
            r    = $random(seed);
            cfg  = i[1:0];
            ps   = i[3:2];
            f    = (ps == 2'h0) ? 1 : (ps == 2'h1) ? 4 : 16;
            per  = (r[2:0] == 3'h0) ? 1 : int'(r[2:0]);
            duty = int'(r[12:3]) % (4 * per + 8);
            if (i == 0) duty = 0;
            if (i == 1) duty = 4 * per + 3;
            if (i == 2) duty = 4 * per + 4;
            len  = (per + 1) * 4 * f;
            m    = (duty > 4 * per + 3) ? len : duty * f;
            // timer off first so a shorter period never waits out a wrap
            wr(`EPWM_OFS_TIMER_CTL, 8'h00);
            wr(`EPWM_OFS_PERIOD, per[7:0]);
            wr(`EPWM_OFS_DUTY_HIGH, duty[9:2]);
            wr(`EPWM_OFS_CONTROL, {cfg, duty[1:0], 4'h1});
            wr(`EPWM_OFS_TIMER_CTL, {5'h0, 1'b1, ps});
            repeat (3 * len) @(posedge clk_i);
            wb(1'b0, `EPWM_OFS_SHADOW, 8'h00, q);
            check("shadow", q, {24'h0, duty[9:2]});
            wr(`EPWM_OFS_SHADOW, ~duty[9:2]);
            wb(1'b0, `EPWM_OFS_SHADOW, 8'h00, q);
            check("shadow locked", q, {24'h0, duty[9:2]});
            measure(len);
            for (int k = 0; k < 4; k++) begin
                check("pin high time", {16'h0, hi[k]}, exp_hi(cfg, k, m, len));
            end
            wb(1'b0, `EPWM_OFS_STATUS, 8'h00, q);
            if (ps == 2'h2 && q[7:0] < per) begin
                wr(`EPWM_OFS_DUTY_HIGH, ~duty[9:2]);
                wb(1'b0, `EPWM_OFS_SHADOW, 8'h00, q);
                check("shadow mid period", q, {24'h0, duty[9:2]});
                repeat (len) @(posedge clk_i);
                wb(1'b0, `EPWM_OFS_SHADOW, 8'h00, q);
                check("shadow at period end", q, {24'h0, ~duty[9:2]});
            end
            $display("case %0d done", i);
        end
        wr(`EPWM_OFS_CONTROL, 8'h00);
        repeat (4) @(posedge clk_i);
        check("pins with mode off", {28'h0, pins}, 32'h0);
        $display("mode off test done");
        test_done();
    end
endmodule

`default_nettype wire
